// >>> hdl/spc_postdiv.sv
// post divider: symmetric toggle divider by 2, 4, 8 or 16
`timescale 1ns/10ps
module spc_postdiv
  import spc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       run,
  input  wire logic [1:0] ratio_sel,
  output logic            div_out
);
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  logic       out_r;
  logic       out_nxt;
  logic [2:0] half_last;

  // half period is 2^sel ticks, so high and low last equally long while ratio_sel holds
  always_comb
  begin
    half_last = 3'((4'h1 << ratio_sel) - 4'h1);
    cnt_nxt   = cnt_r;
    out_nxt   = out_r;
    if (!run)
    begin
      cnt_nxt = 3'h0;
      out_nxt = 1'b0;
    end
    else if (cnt_r >= half_last)  // >= so a ratio cut mid-phase cannot stall
    begin
      cnt_nxt = 3'h0;
      out_nxt = ~out_r;           // [RQ5]
    end
    else
    begin
      cnt_nxt = 3'(cnt_r + 3'h1);
    end
  end

  // registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt_r <= 3'h0;
      out_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      out_r <= out_nxt;
    end
  end

  assign div_out = out_r;
endmodule : spc_postdiv

// >>> hdl/spc_top.sv
// system pll control: registers, range check, lock timer, glitch-free output switch
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/10ps
// Summary of operation
// RQ1 - reference clock from the oscillator must be 1 to 25 MHz
// RQ2 - loop multiplier programmable as any integer from 1 to 32
// RQ3 - oscillator kept within 156 to 320 MHz using the feedback divider
// RQ4 - post divider offers only ratios 2, 4, 8 and 16
// RQ5 - output clock always has a 50 % duty cycle; a ratio change during a low phase alters that low phase
// RQ6 - after reset the loop is off and bypassed until software enables it
// RQ7 - software configures, enables, waits for lock, then selects the loop
// RQ8 - loop reports lock within a settling time of 100 microseconds
// RQ9 - lock readable; bypass passes the reference clock without glitches
module spc_top
  import spc_pkg::*;
(
  input  wire logic        MCLK,
  input  wire logic        RST,
  input  wire logic        REF_CLK,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  output logic             CLK_OUT,
  output logic             PLL_POWER,
  output logic             PLL_LOCK,
  output logic             LOOP_ACTIVE,
  output logic             IRQ
);
  import spc_pkg::*;

  logic [10:0] ctrl_r;
  logic [10:0] ctrl_nxt;
  logic [14:0] ref_khz_r;
  logic [14:0] ref_khz_nxt;
  logic [2:0]  irq_mask_r;
  logic [2:0]  irq_mask_nxt;
  logic [2:0]  irq_stat_r;
  logic [2:0]  irq_stat_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic        slverr_r;
  logic        slverr_nxt;
  logic [11:0] lock_cnt_r;
  logic [11:0] lock_cnt_nxt;
  logic        lock_r;
  logic        lock_nxt;
  logic        range_err_r;
  logic        range_err_nxt;
  spc_src_e    src_r;
  spc_src_e    src_nxt;
  logic [1:0]  ratio_r;
  logic [1:0]  ratio_nxt;
  logic        ref_smp_r;
  logic        out_r;
  logic        out_nxt;

  logic        setup_ph;
  logic        access_ph;
  logic        wr_ctrl;
  logic        wr_ref;
  logic        wr_mask;
  logic        rd_stat_clr;
  logic        addr_ok;
  logic        loop_en;
  logic [5:0]  mult;
  logic [3:0]  fb_ratio;
  logic [23:0] ref_ext;
  logic [23:0] cco_khz;
  logic        in_range;
  logic        loop_clk;
  spc_src_e    want_src;
  logic        want_val;

  // bus phases: data is prepared in setup so prdata leaves a flip-flop
  always_comb
  begin
    setup_ph    = PSEL && !PENABLE;
    access_ph   = PSEL && PENABLE;
    addr_ok     = (PADDR == SPC_OFF_CTRL) || (PADDR == SPC_OFF_STATUS) || (PADDR == SPC_OFF_REF_KHZ) ||
                  (PADDR == SPC_OFF_IRQ_STAT) || (PADDR == SPC_OFF_IRQ_MASK);
    wr_ctrl     = access_ph && PWRITE && (PADDR == SPC_OFF_CTRL);
    wr_ref      = access_ph && PWRITE && (PADDR == SPC_OFF_REF_KHZ);
    wr_mask     = access_ph && PWRITE && (PADDR == SPC_OFF_IRQ_MASK);
    rd_stat_clr = access_ph && !PWRITE && (PADDR == SPC_OFF_IRQ_STAT);
  end

  // loop settings decoded from the control word
  always_comb
  begin
    loop_en  = ctrl_r[SPC_CTRL_EN];
    // ratio frozen while the divider is high, so a running high phase keeps its length; a low phase takes up a new ratio
    ratio_nxt = loop_clk ? ratio_r : ctrl_r[SPC_CTRL_PDIV_LO +: 2];
    mult     = 6'({1'b0, ctrl_r[SPC_CTRL_MSEL_LO +: 5]} + 6'h01);  // field 0..31 means 1..32 [RQ2]
    fb_ratio = 4'(4'h1 << ctrl_r[SPC_CTRL_FB_LO +: 2]);
    ref_ext  = {9'h00, ref_khz_r};
    cco_khz  = 24'(ref_ext * {18'h0000, mult} * {20'h00000, fb_ratio});  // [RQ3]
    // refuse to lock outside the allowed input or oscillator band
    in_range = (ref_ext >= SPC_REF_MIN_KHZ) && (ref_ext <= SPC_REF_MAX_KHZ) &&  // [RQ1]
               (cco_khz >= SPC_CCO_MIN_KHZ) && (cco_khz <= SPC_CCO_MAX_KHZ);    // [RQ3]
  end

  // register file next values
  always_comb
  begin
    ctrl_nxt     = ctrl_r;
    ref_khz_nxt  = ref_khz_r;
    irq_mask_nxt = irq_mask_r;
    prdata_nxt   = prdata_r;
    slverr_nxt   = 1'b0;
    if (wr_ctrl)
    begin
      ctrl_nxt = PWDATA[SPC_CTRL_BITS-1:0];
    end
    if (wr_ref)
    begin
      ref_khz_nxt = PWDATA[14:0];
    end
    if (wr_mask)
    begin
      irq_mask_nxt = PWDATA[SPC_IRQ_BITS-1:0];
    end
    if (setup_ph)
    begin
      slverr_nxt = !addr_ok;  // unmapped offsets end in an error, read as zero
      case (PADDR)
        SPC_OFF_CTRL:     prdata_nxt = {21'h00000, ctrl_r};
        SPC_OFF_STATUS:   prdata_nxt = {29'h0000000, (src_r == SPC_SRC_LOOP), range_err_r, lock_r};  // [RQ9]
        SPC_OFF_REF_KHZ:  prdata_nxt = {17'h0000, ref_khz_r};
        SPC_OFF_IRQ_STAT: prdata_nxt = {29'h0000000, irq_stat_r};
        SPC_OFF_IRQ_MASK: prdata_nxt = {29'h0000000, irq_mask_r};
        default:          prdata_nxt = 32'h00000000;
      endcase
    end
    else
    begin
      prdata_nxt = 32'h00000000;  // cleared at the access edge, so an idle bus reads zero
    end
  end

  // lock timer: any setting change restarts settling, the loop is not trusted meanwhile
  always_comb
  begin
    lock_cnt_nxt  = lock_cnt_r;
    lock_nxt      = lock_r;
    range_err_nxt = loop_en && !in_range;
    if (!loop_en || !in_range || (wr_ctrl && (PWDATA[SPC_CTRL_BITS-1:0] != ctrl_r)) ||
        (wr_ref && (PWDATA[14:0] != ref_khz_r)))
    begin
      lock_cnt_nxt = 12'h000;
      lock_nxt     = 1'b0;
    end
    else if (lock_cnt_r >= SPC_LOCK_CYCLES - 12'h001)
    begin
      lock_nxt = 1'b1;  // [RQ8]
    end
    else
    begin
      lock_cnt_nxt = 12'(lock_cnt_r + 12'h001);
    end
  end

  // sticky events; a read clears, but an event in the same cycle survives
  always_comb
  begin
    irq_stat_nxt = irq_stat_r;
    if (rd_stat_clr)
    begin
      irq_stat_nxt = 3'h0;
    end
    if (lock_nxt && !lock_r)
    begin
      irq_stat_nxt[SPC_IRQ_LOCKED] = 1'b1;
    end
    if (!lock_nxt && lock_r)
    begin
      irq_stat_nxt[SPC_IRQ_LOST] = 1'b1;
    end
    if (range_err_nxt && !range_err_r)
    begin
      irq_stat_nxt[SPC_IRQ_RANGE] = 1'b1;
    end
  end

  // the loop output can only be chosen once locked; a lost lock falls back to bypass
  always_comb
  begin
    want_src = (ctrl_r[SPC_CTRL_USE_LOOP] && lock_r) ? SPC_SRC_LOOP : SPC_SRC_BYPASS;  // [RQ7] [RQ6]
    want_val = (want_src == SPC_SRC_LOOP) ? loop_clk : ref_smp_r;
    src_nxt  = src_r;
    // switch only while both old output and new source are low, so no runt pulse
    if ((want_src != src_r) && !out_r && !want_val)
    begin
      src_nxt = want_src;  // [RQ9]
    end
    out_nxt = (src_nxt == SPC_SRC_LOOP) ? loop_clk : ref_smp_r;  // bypass copies reference [RQ9]
    // while a switch waits the old source may end its high phase, never start one
    if (src_nxt != want_src)
    begin
      out_nxt = out_r && out_nxt;  // no runt pulse [RQ5]
    end
  end

  // oscillator tick stands for the block clock; the divider gives the output ratio
  spc_postdiv u_postdiv
  (
    .clk       (MCLK),
    .rst       (RST),
    .run       (lock_r || loop_clk),  // a high phase finishes even after lock is lost
    .ratio_sel (ratio_r),             // 2, 4, 8 or 16 only [RQ4]
    .div_out   (loop_clk)
  );

  // all state registers; reset leaves the loop powered down and bypassed
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      ctrl_r      <= SPC_CTRL_RST;  // [RQ6]
      ref_khz_r   <= SPC_REF_KHZ_RST;
      irq_mask_r  <= SPC_IRQ_MASK_RST;
      irq_stat_r  <= 3'h0;
      prdata_r    <= 32'h00000000;
      slverr_r    <= 1'b0;
      lock_cnt_r  <= 12'h000;
      lock_r      <= 1'b0;
      range_err_r <= 1'b0;
      src_r       <= SPC_SRC_BYPASS;
      ratio_r     <= SPC_CTRL_RST[SPC_CTRL_PDIV_LO +: 2];
      ref_smp_r   <= 1'b0;
      out_r       <= 1'b0;
    end
    else
    begin
      ctrl_r      <= ctrl_nxt;
      ref_khz_r   <= ref_khz_nxt;
      irq_mask_r  <= irq_mask_nxt;
      irq_stat_r  <= irq_stat_nxt;
      prdata_r    <= prdata_nxt;
      slverr_r    <= slverr_nxt;
      lock_cnt_r  <= lock_cnt_nxt;
      lock_r      <= lock_nxt;
      range_err_r <= range_err_nxt;
      src_r       <= src_nxt;
      ratio_r     <= ratio_nxt;
      ref_smp_r   <= REF_CLK;
      out_r       <= out_nxt;
    end
  end

  // outputs
  assign PRDATA      = prdata_r;
  assign PREADY      = PSEL && PENABLE;  // one access cycle, no wait states
  assign PSLVERR     = slverr_r && PSEL && PENABLE;
  assign CLK_OUT     = out_r;
  assign PLL_POWER   = loop_en;
  assign PLL_LOCK    = lock_r;
  assign LOOP_ACTIVE = (src_r == SPC_SRC_LOOP);
  assign IRQ         = |(irq_stat_r & irq_mask_r);
endmodule : spc_top

// >>> hdl/spc_top_dummy_never.sv
// no logic here: the block is spc_top with its post divider spc_postdiv

// >>> pkg/spc_pkg.sv
// constants and register map of the system pll control block
package spc_pkg;
  // register byte offsets
  localparam logic [7:0]  SPC_OFF_CTRL      = 8'h00;
  localparam logic [7:0]  SPC_OFF_STATUS    = 8'h04;
  localparam logic [7:0]  SPC_OFF_REF_KHZ   = 8'h08;
  localparam logic [7:0]  SPC_OFF_IRQ_STAT  = 8'h0C;
  localparam logic [7:0]  SPC_OFF_IRQ_MASK  = 8'h10;
  // control field positions
  localparam int          SPC_CTRL_EN       = 0;
  localparam int          SPC_CTRL_USE_LOOP = 1;
  localparam int          SPC_CTRL_MSEL_LO  = 2;
  localparam int          SPC_CTRL_FB_LO    = 7;
  localparam int          SPC_CTRL_PDIV_LO  = 9;
  localparam int          SPC_CTRL_BITS     = 11;
  // status and interrupt bit positions
  localparam int          SPC_ST_LOCK       = 0;
  localparam int          SPC_ST_RANGE_ERR  = 1;
  localparam int          SPC_ST_LOOP_ACT   = 2;
  localparam int          SPC_IRQ_LOCKED    = 0;
  localparam int          SPC_IRQ_LOST      = 1;
  localparam int          SPC_IRQ_RANGE     = 2;
  localparam int          SPC_IRQ_BITS      = 3;
  // reset values: loop off, bypass selected, multiplier 1, smallest ratios
  localparam logic [10:0] SPC_CTRL_RST      = 11'h000;
  localparam logic [14:0] SPC_REF_KHZ_RST   = 15'h2EE0;
  localparam logic [2:0]  SPC_IRQ_MASK_RST  = 3'h0;
  // frequency limits in kHz
  localparam logic [23:0] SPC_REF_MIN_KHZ   = 24'h0003E8;
  localparam logic [23:0] SPC_REF_MAX_KHZ   = 24'h0061A8;
  localparam logic [23:0] SPC_CCO_MIN_KHZ   = 24'h026160;
  localparam logic [23:0] SPC_CCO_MAX_KHZ   = 24'h04E200;
  // settling time and its cycle count at the block clock
  localparam int          SPC_MCLK_KHZ      = 20000;
  localparam int          SPC_SETTLE_US     = 100;
  localparam int          SPC_SETTLE_CYC    = (SPC_SETTLE_US * SPC_MCLK_KHZ + 999) / 1000;
  localparam int          SPC_LOCK_CW       = 12;
  localparam logic [11:0] SPC_LOCK_CYCLES   = SPC_LOCK_CW'(SPC_SETTLE_CYC);
  // output clock source selection
  typedef enum logic [0:0]
  {
    SPC_SRC_BYPASS = 1'b0,
    SPC_SRC_LOOP   = 1'b1
  } spc_src_e;
endpackage : spc_pkg

// >>> sim/spc_ref_osc.sv
// reference oscillator model feeding the reference clock input
`timescale 1ns/10ps
module spc_ref_osc
(
  input  wire logic slow,
  output logic      ref_clk
);
  // free running: 12.5 MHz, or 1 MHz when slow, both inside the band
  // half periods are whole 10 ns steps, so an edge never meets a rising block clock edge
  initial
  begin
    ref_clk = 1'b0;
    forever #((slow === 1'b1) ? 500.0 : 40.0) ref_clk = ~ref_clk;
  end
endmodule : spc_ref_osc

// >>> sim/spc_top_monitor.sv
// port checker of the system pll control block
`timescale 1ns/10ps
module spc_top_monitor
  import spc_pkg::*;
(
  input wire logic        MCLK,
  input wire logic        RST,
  input wire logic        REF_CLK,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        CLK_OUT,
  input wire logic        PLL_POWER,
  input wire logic        PLL_LOCK,
  input wire logic        LOOP_ACTIVE,
  input wire logic        IRQ
);
  localparam int SETTLE = SPC_SETTLE_CYC;
  logic        cko_r;
  logic        seen_r;
  logic [4:0]  run_r;
  logic [4:0]  hi_r;
  logic [11:0] on_r;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  // run lengths of the output; seen only after a full high phase in loop mode
  always_ff @(posedge MCLK)
  begin
    cko_r <= CLK_OUT;
    run_r <= (CLK_OUT != cko_r) ? 5'h01 : run_r + 5'h01;
    if (cko_r && !CLK_OUT)
      hi_r <= run_r;
    seen_r <= (!LOOP_ACTIVE || RST) ? 1'b0 : (seen_r || (cko_r && !CLK_OUT));
    on_r <= (!PLL_POWER || PLL_LOCK || RST) ? 12'h000 : on_r + 12'h001;
  end
  chk_reset_state: assert property ($past(RST) |-> !PLL_POWER && !PLL_LOCK && !LOOP_ACTIVE && !IRQ)
    else $error("outputs not cleared by reset");
  chk_lock_power: assert property (PLL_LOCK |-> PLL_POWER)
    else $error("lock without power");
  chk_lock_settle: assert property ($rose(PLL_LOCK) |-> on_r >= SETTLE - 2)
    else $error("lock before settling");
  chk_loop_locked: assert property ($rose(LOOP_ACTIVE) |-> PLL_LOCK && PLL_POWER)
    else $error("loop selected without lock");
  chk_bypass_follow: assert property (!LOOP_ACTIVE && !PLL_LOCK && !$past(PLL_LOCK, 3) && !$past(RST, 3)
    |-> CLK_OUT == $past(REF_CLK, 2))
    else $error("bypass output does not follow reference");
  chk_ratio_set: assert property (cko_r && !CLK_OUT && seen_r && LOOP_ACTIVE
    |-> run_r inside {5'h01, 5'h02, 5'h04, 5'h08})
    else $error("illegal output half period");
  chk_duty_even: assert property (!cko_r && CLK_OUT && seen_r && LOOP_ACTIVE |-> run_r == hi_r)
    else $error("output duty not even");
  chk_ready_now: assert property (PSEL && PENABLE |-> PREADY)
    else $error("access not ready at once");
  chk_idle_bus: assert property (!PSEL |-> PRDATA == 32'h0 && !PSLVERR && !PREADY)
    else $error("bus outputs active while idle");
  cover property ($rose(LOOP_ACTIVE));
  cover property ($rose(PSLVERR));
  cover property ($rose(IRQ));
endmodule : spc_top_monitor

// >>> sim/system_pll_control_test.sv
// self-checking bench of the system pll control block
`timescale 1ns/10ps
module system_pll_control_test;
  import spc_pkg::*;
  logic        mclk, rst, psel, penable, pwrite, slow, ref_clk;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rq;
  logic        pready, pslverr, clk_out, pll_power, pll_lock, loop_active, irq, re;
  int          err_total, checked;
  // reference kHz, multiplier field, feedback field, range error expected
  int          rng[10][4] = '{'{12000, 0, 0, 1}, '{19500, 7, 0, 0}, '{19499, 7, 0, 1},
                              '{5000, 31, 1, 0}, '{5001, 31, 1, 1}, '{25000, 0, 3, 0},
                              '{26000, 0, 3, 1}, '{1000, 31, 3, 0}, '{999, 31, 3, 1},
                              '{5000, 15, 2, 0}};
  spc_ref_osc osc (.slow(slow), .ref_clk(ref_clk));
  spc_top dut (.MCLK(mclk), .RST(rst), .REF_CLK(ref_clk), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .CLK_OUT(clk_out), .PLL_POWER(pll_power), .PLL_LOCK(pll_lock),
    .LOOP_ACTIVE(loop_active), .IRQ(irq));
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task wrap_up;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  // one apb transfer; answer taken at the rising edge where pready is seen high
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do
    begin
      @(posedge mclk);
    end
    while (pready !== 1'b1);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // callers look at outputs only once the access edge has settled
    @(negedge mclk);
  endtask : apb
  function logic [31:0] ctl(input int en, input int lp, input int ms, input int fb, input int pd);
    return 32'(en + lp * 2 + ms * 4 + fb * 128 + pd * 512);
  endfunction : ctl
  task t_reset;
    apb(1'b0, SPC_OFF_CTRL, 32'h0);
    chk(rq, 32'(SPC_CTRL_RST));
    apb(1'b0, SPC_OFF_REF_KHZ, 32'h0);
    chk(rq, 32'(SPC_REF_KHZ_RST));
    apb(1'b0, SPC_OFF_IRQ_MASK, 32'h0);
    chk(rq, 32'(SPC_IRQ_MASK_RST));
    chk(32'({pll_power, pll_lock, loop_active, irq}), 32'h0);
    apb(1'b1, SPC_OFF_STATUS, 32'hFFFFFFFF);
    chk(32'(re), 32'h0);
    apb(1'b0, SPC_OFF_STATUS, 32'h0);
    chk(rq, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk({rq[30:0], re}, 32'h1);
  endtask : t_reset
  // range boundaries of reference and oscillator, masked interrupt
  task t_range;
    foreach (rng[i])
    begin
      apb(1'b1, SPC_OFF_REF_KHZ, 32'(rng[i][0]));
      apb(1'b1, SPC_OFF_CTRL, ctl(1, 0, rng[i][1], rng[i][2], 0));
      repeat (3) @(posedge mclk);
      apb(1'b0, SPC_OFF_STATUS, 32'h0);
      chk(32'(rq[SPC_ST_RANGE_ERR]), 32'(rng[i][3]));
      apb(1'b1, SPC_OFF_CTRL, 32'h0);
    end
    chk(32'(irq), 32'h0);
    apb(1'b0, SPC_OFF_IRQ_STAT, 32'h0);
    chk(32'(rq[SPC_IRQ_RANGE]), 32'h1);
  endtask : t_range
  // loop requested early, must wait for lock; then output ratio and duty
  task t_lock(input int pd);
    int n;
    int h;
    int l;
    apb(1'b1, SPC_OFF_REF_KHZ, 32'd12000);
    apb(1'b1, SPC_OFF_IRQ_MASK, 32'h3);
    apb(1'b0, SPC_OFF_IRQ_STAT, 32'h0);
    apb(1'b1, SPC_OFF_CTRL, ctl(1, 1, 12, 0, pd));
    repeat (1000) @(negedge mclk);
    chk(32'(loop_active), 32'h0);
    n = 1000;
    while (pll_lock !== 1'b1 && n < 3000)
    begin
      @(negedge mclk);
      n++;
    end
    chk(32'(n >= SPC_SETTLE_CYC - 10 && n <= SPC_SETTLE_CYC), 32'h1);
    apb(1'b0, SPC_OFF_STATUS, 32'h0);
    chk(32'(rq[SPC_ST_LOCK]), 32'h1);
    chk(32'(irq), 32'h1);
    apb(1'b0, SPC_OFF_IRQ_STAT, 32'h0);
    chk(rq, (pd == 0) ? 32'h1 : 32'h3);
    chk(32'(irq), 32'h0);
    n = 0;
    while (loop_active !== 1'b1 && n < 100)
    begin
      @(negedge mclk);
      n++;
    end
    chk(32'(loop_active), 32'h1);
    while (clk_out !== 1'b0) @(negedge mclk);
    while (clk_out !== 1'b1) @(negedge mclk);
    h = 0;
    l = 0;
    while (clk_out === 1'b1)
    begin
      @(negedge mclk);
      h++;
    end
    while (clk_out === 1'b0)
    begin
      @(negedge mclk);
      l++;
    end
    chk(32'(h), 32'(1 << pd));
    chk(32'(l), 32'(h));
  endtask : t_lock
  // power off in loop mode, back to bypass on a slow reference
  task t_off;
    int n;
    logic p;
    apb(1'b1, SPC_OFF_CTRL, 32'h0);
    chk(32'({pll_power, pll_lock}), 32'h0);
    n = 0;
    while (loop_active !== 1'b0 && n < 100)
    begin
      @(negedge mclk);
      n++;
    end
    chk(32'(loop_active), 32'h0);
    chk(32'(irq), 32'h1);
    apb(1'b0, SPC_OFF_IRQ_STAT, 32'h0);
    chk(32'(rq[SPC_IRQ_LOST]), 32'h1);
    slow <= 1'b1;
    repeat (40) @(negedge mclk);
    n = 0;
    repeat (400)
    begin
      p = clk_out;
      @(negedge mclk);
      n += int'(clk_out === 1'b1 && p === 1'b0);
    end
    chk(32'(n >= 19 && n <= 21), 32'h1);
  endtask : t_off
  initial
  begin
    #2000000;
    err_total++;
    wrap_up;
  end
  initial
  begin
    {rst, psel, penable, pwrite, slow, paddr, pwdata} = {1'b1, 44'h0};
    err_total = 0;
    checked = 0;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    t_reset;
    t_range;
    for (int p = 0; p < 4; p++)
      t_lock(p);
    t_off;
    wrap_up;
  end
endmodule : system_pll_control_test
bind spc_top spc_top_monitor mon (.MCLK(MCLK), .RST(RST), .REF_CLK(REF_CLK), .PSEL(PSEL),
  .PENABLE(PENABLE), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .CLK_OUT(CLK_OUT),
  .PLL_POWER(PLL_POWER), .PLL_LOCK(PLL_LOCK), .LOOP_ACTIVE(LOOP_ACTIVE), .IRQ(IRQ));
